// file: hw/sbt_pkg.sv
// Package: shared constants and types of the sixteen-bit timer block
// Operation
// - System clock select 01 enters secondary run
// - Sleep with idle bit clear enters secondary idle
// - Status bit 6 shows timer oscillator clocking device
// - Status drops when clock monitor switches away
// - Config bit set selects oscillator low power
// - Count pair counts up, wraps to zero
// - Wrap sets sticky overflow flag bit 0
// - Enable bit 0 gates overflow interrupt request
// - Compare special event trigger clears count pair
// - Special event reset skipped in unsynchronized mode
// - Software count write beats special event reset
// - Second compare unit reset never sets flag
// - Unsynchronized mode needs falling edge after update
// - Source select picks instruction cycle or pin
// - Prescale field divides by 1, 2, 4, 8
// - Wide mode low read buffers high byte
// - Wide low write loads high; clears prescaler
package sbt_pkg;
  // ****************************************************************
  // Register word indices, byte address is index times four
  // ****************************************************************
  localparam logic [2:0] IDX_CTRL = 3'h0; // counter_control
  localparam logic [2:0] IDX_CNT_LO = 3'h1; // count_low_byte
  localparam logic [2:0] IDX_CNT_HI = 3'h2; // count_high_byte
  localparam logic [2:0] IDX_FLAGS = 3'h3; // peripheral_irq_flags
  localparam logic [2:0] IDX_ENABLES = 3'h4; // peripheral_irq_enables
  localparam logic [2:0] IDX_PRIO = 3'h5; // peripheral_irq_priorities
  localparam logic [2:0] IDX_OSCCTL = 3'h6; // oscillator_control_reg
  localparam logic [2:0] IDX_INTMC = 3'h7; // interrupt_master_control
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTL_WIDE = 7; // wide_access_enable
  localparam int CTL_STATUS = 6; // osc_clock_status, read only
  localparam int CTL_PRESC_HI = 5; // input_prescale_select msb
  localparam int CTL_PRESC_LO = 4; // input_prescale_select lsb
  localparam int CTL_OSC_EN = 3; // osc_enable
  localparam int CTL_SYNC_DIS = 2; // external_sync_disable
  localparam int CTL_SRC = 1; // count_source_select
  localparam int CTL_ON = 0; // counter_on
  localparam int OVF_BIT = 0; // overflow flag, enable, priority
  localparam int OSC_IDLE = 7; // idle_on_sleep_select
  localparam logic [1:0] SCS_SECONDARY = 2'h1; // system_clock_select
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb; // compare mode
  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00; // every register
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam int CLK_HZ = 40000000; // hclk rate
  localparam int INSTR_CYCLES = 4; // hclk cycles per instruction cycle
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_CYCLES - 1);
  // Power-managed clocking state
  typedef enum logic [2:0] {
    PM_PRIMARY = 3'b001,
    PM_SEC_RUN = 3'b010,
    PM_SEC_IDLE = 3'b100
  } sbt_pm_t;
endpackage

// file: hw/sbt_prescale.sv
// Input prescaler: divides count ticks by 1, 2, 4 or 8
`timescale 1ns/100ps
module sbt_prescale
  import sbt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic clear,
  input wire logic [1:0] sel,
  output logic pulse
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0] cnt; // Ticks seen in this period
    logic pulse; // One-cycle count advance
  } sbt_presc_t;
  sbt_presc_t st_ff;
  sbt_presc_t nxt_st;
  logic [2:0] last; // Terminal count for the selected ratio

  // Divide ticks; a clear restarts the period and wins over a tick
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pulse = 1'b0;
    case (sel)
      2'h0: last = 3'h0;
      2'h1: last = 3'h1;
      2'h2: last = 3'h3;
      default: last = 3'h7;
    endcase
    if (clear) begin
      nxt_st.cnt = 3'h0;
    end else if (tick) begin
      if (st_ff.cnt >= last) begin
        nxt_st.cnt = 3'h0;
        nxt_st.pulse = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 3'h1;
      end
    end
  end

  // Register state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse = st_ff.pulse;

  a_clear_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    clear |=> (st_ff.cnt == 3'h0) && !pulse)
    else $error("prescaler not cleared");
  a_div_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (sel == 2'h0) && tick && !clear |=> pulse)
    else $error("divide by one missed a tick");
endmodule

// file: hw/sbt_sync.sv
// Three-stage synchronizer for the external count clock pin
`timescale 1ns/100ps
module sbt_sync
  import sbt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  output logic stage2,
  output logic stage3
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic s1; // Metastable stage, read only by s2
    logic s2;
    logic s3;
  } sbt_sync_t;
  sbt_sync_t st_ff;
  sbt_sync_t nxt_st;

  // Shift the pin through the chain
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  // Register the chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stage2 = st_ff.s2;
  assign stage3 = st_ff.s3;
endmodule

// file: hw/sbt_timer.sv
// Sixteen-bit timer/counter with oscillator status, AHB-Lite slave
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module sbt_timer
  import sbt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic count_clk_pin,
  input wire logic cmp_a_uses_timer,
  input wire logic [3:0] compare_unit_a_mode,
  input wire logic cmp_a_trig,
  input wire logic cmp_b_uses_timer,
  input wire logic [3:0] compare_unit_b_mode,
  input wire logic cmp_b_trig,
  input wire logic sleep_exec,
  input wire logic wake_event,
  input wire logic clock_monitor_fail,
  input wire logic osc_low_power_config,
  output logic overflow_irq,
  output logic overflow_irq_high,
  output logic cpu_on_osc_clock,
  output logic sec_idle_mode,
  output logic osc_enable_out,
  output logic osc_low_power
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ctrl; // counter_control, status bit kept zero here
    logic status; // osc_clock_status
    logic [15:0] count; // count_pair
    logic [7:0] hbuf; // High byte buffer for wide access
    logic [7:0] flags; // peripheral_irq_flags
    logic [7:0] enables; // peripheral_irq_enables
    logic [7:0] prio; // peripheral_irq_priorities
    logic [7:0] oscctl; // oscillator_control_reg
    logic [7:0] intmc; // interrupt_master_control
    logic armed; // Falling edge seen since last update
    logic ext_lvl; // Filtered pin level
    logic [1:0] div; // Instruction cycle divider
    sbt_pm_t pm; // Power-managed clocking state
    logic dvalid; // Data phase of a mapped access pending
    logic dwrite;
    logic [2:0] didx;
    logic [31:0] rdata;
    logic irq;
    logic irq_high;
    logic idle;
    logic lp; // Oscillator power level
    logic cfg_taken; // Config bit captured since reset
  } sbt_state_t;
  sbt_state_t st_ff;
  sbt_state_t nxt_st;

  logic pin_s2; // Second synchronizer stage
  logic pin_s3; // Third synchronizer stage
  logic presc_pulse; // Prescaled count advance
  logic presc_clear; // Low-byte write restarts prescaler
  logic tick; // Raw count tick before prescaling
  logic instr_en; // One pulse per instruction cycle
  logic ext_rise; // Filtered rising edge of the pin
  logic ext_fall; // Filtered falling edge of the pin
  logic async_mode; // Pin counted without synchronization
  logic addr_phase; // Transfer taken this edge, before the address map check
  logic [2:0] aidx; // Address phase word index
  logic wr_lo; // Data phase write to count_low_byte
  logic wr_hi; // Data phase write to count_high_byte
  logic sev_a; // Special event from first compare unit
  logic sev_b; // Special event from second compare unit
  logic sev; // Special event reset that applies
  logic wrap; // Count passes from max to zero
  logic [7:0] rd_byte; // Read mux output

  // ****************************************************************
  // Pin synchronizer and prescaler
  // ****************************************************************
  sbt_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(count_clk_pin),
    .stage2(pin_s2),
    .stage3(pin_s3)
  );

  sbt_prescale u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .clear(presc_clear),
    .sel(st_ff.ctrl[CTL_PRESC_HI:CTL_PRESC_LO]),
    .pulse(presc_pulse)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    // Instruction cycle enable from the hclk divider
    instr_en = (st_ff.div == INSTR_LAST);
    nxt_st.div = st_ff.div + 2'h1;
    // A pin change counts once stages two and three agree
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    if ((pin_s2 == pin_s3) && (pin_s3 != st_ff.ext_lvl)) begin
      nxt_st.ext_lvl = pin_s3;
      ext_rise = pin_s3;
      ext_fall = !pin_s3;
    end
    async_mode = st_ff.ctrl[CTL_SRC] && st_ff.ctrl[CTL_SYNC_DIS];
    if (ext_fall) begin
      nxt_st.armed = 1'b1;
    end
    // Tick source; nothing reaches the prescaler while off
    if (!st_ff.ctrl[CTL_ON]) begin
      tick = 1'b0;
    end else if (st_ff.ctrl[CTL_SRC]) begin
      tick = ext_rise && (st_ff.armed || !async_mode);
    end else begin
      tick = instr_en;
    end
    // Data phase decode
    wr_lo = st_ff.dvalid && st_ff.dwrite && (st_ff.didx == IDX_CNT_LO);
    wr_hi = st_ff.dvalid && st_ff.dwrite && (st_ff.didx == IDX_CNT_HI);
    presc_clear = wr_lo;
    // Special event triggers; unreliable async path is not taken
    sev_a = cmp_a_trig && cmp_a_uses_timer &&
            (compare_unit_a_mode == MODE_SPECIAL_EVENT);
    sev_b = cmp_b_trig && cmp_b_uses_timer &&
            (compare_unit_b_mode == MODE_SPECIAL_EVENT);
    sev = (sev_a || sev_b) && !async_mode;
    wrap = presc_pulse && (st_ff.count == COUNT_MAX);
    // Count update: write, then special event, then increment
    if (presc_pulse) begin
      nxt_st.count = st_ff.count + 16'h0001;
    end
    if (sev) begin
      nxt_st.count = RST_COUNT;
    end
    if (wr_lo) begin
      // Wide mode moves the buffered high byte in together
      nxt_st.count[7:0] = hwdata[7:0];
      if (st_ff.ctrl[CTL_WIDE]) begin
        nxt_st.count[15:8] = st_ff.hbuf;
      end else if (sev) begin
        nxt_st.count[15:8] = st_ff.count[15:8];
      end
    end
    if (wr_hi) begin
      if (st_ff.ctrl[CTL_WIDE]) begin
        nxt_st.hbuf = hwdata[7:0];
      end else begin
        nxt_st.count[15:8] = hwdata[7:0];
        if (sev && !wr_lo) begin
          nxt_st.count[7:0] = st_ff.count[7:0];
        end
      end
    end
    // Any update needs a fresh falling edge before counting in unsynchronized mode
    if (wr_lo || wr_hi) begin
      nxt_st.armed = 1'b0;
    end
    // Other register writes
    if (st_ff.dvalid && st_ff.dwrite) begin
      case (st_ff.didx)
        IDX_CTRL: begin
          nxt_st.ctrl = hwdata[7:0];
          nxt_st.ctrl[CTL_STATUS] = 1'b0; // Read-only position
        end
        IDX_FLAGS: nxt_st.flags = hwdata[7:0];
        IDX_ENABLES: nxt_st.enables = hwdata[7:0];
        IDX_PRIO: nxt_st.prio = hwdata[7:0];
        IDX_OSCCTL: nxt_st.oscctl = hwdata[7:0];
        IDX_INTMC: nxt_st.intmc = hwdata[7:0];
        default: nxt_st.intmc = nxt_st.intmc;
      endcase
    end
    // Overflow set beats a software clear; a reset is not a wrap
    if (wrap && !sev) begin
      nxt_st.flags[OVF_BIT] = 1'b1;
    end
    // Address phase: take the transfer, latch read data
    addr_phase = hsel && hready && htrans[1];
    aidx = haddr[4:2];
    nxt_st.dvalid = addr_phase && (haddr[31:5] == 27'h0000000);
    nxt_st.dwrite = hwrite;
    nxt_st.didx = aidx;
    case (aidx)
      IDX_CTRL: begin
        rd_byte = st_ff.ctrl;
        rd_byte[CTL_STATUS] = st_ff.status;
      end
      IDX_CNT_LO: rd_byte = st_ff.count[7:0];
      IDX_CNT_HI: rd_byte = st_ff.ctrl[CTL_WIDE] ? st_ff.hbuf :
                            st_ff.count[15:8];
      IDX_FLAGS: rd_byte = st_ff.flags;
      IDX_ENABLES: rd_byte = st_ff.enables;
      IDX_PRIO: rd_byte = st_ff.prio;
      IDX_OSCCTL: rd_byte = st_ff.oscctl;
      default: rd_byte = st_ff.intmc;
    endcase
    nxt_st.rdata = 32'h00000000;
    if (nxt_st.dvalid && !hwrite) begin
      nxt_st.rdata = {24'h000000, rd_byte};
      // Snapshot of the live high byte for a tear-free pair read
      if ((aidx == IDX_CNT_LO) && st_ff.ctrl[CTL_WIDE]) begin
        nxt_st.hbuf = st_ff.count[15:8];
      end
    end
    // Power-managed clocking from the timer oscillator
    case (st_ff.pm)
      PM_PRIMARY: begin
        if ((st_ff.oscctl[1:0] == SCS_SECONDARY) &&
            st_ff.ctrl[CTL_OSC_EN] && !clock_monitor_fail) begin
          nxt_st.pm = PM_SEC_RUN;
        end
      end
      PM_SEC_RUN: begin
        if (clock_monitor_fail ||
            (st_ff.oscctl[1:0] != SCS_SECONDARY)) begin
          nxt_st.pm = PM_PRIMARY;
        end else if (sleep_exec && !st_ff.oscctl[OSC_IDLE]) begin
          nxt_st.pm = PM_SEC_IDLE;
        end
      end
      PM_SEC_IDLE: begin
        if (clock_monitor_fail) begin
          nxt_st.pm = PM_PRIMARY;
        end else if (wake_event) begin
          nxt_st.pm = PM_SEC_RUN;
        end
      end
      default: nxt_st.pm = PM_PRIMARY;
    endcase
    nxt_st.status = (nxt_st.pm != PM_PRIMARY);
    nxt_st.idle = (nxt_st.pm == PM_SEC_IDLE);
    // Interrupt request is masked by the enable bit
    nxt_st.irq = nxt_st.flags[OVF_BIT] && nxt_st.enables[OVF_BIT];
    nxt_st.irq_high = nxt_st.irq && nxt_st.prio[OVF_BIT];
    // Config strap is caught once, after reset release
    if (!st_ff.cfg_taken) begin
      nxt_st.lp = osc_low_power_config;
      nxt_st.cfg_taken = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.pm <= PM_PRIMARY;
      st_ff.count <= RST_COUNT;
      st_ff.ctrl <= RST_BYTE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Zero-wait slave: ready held high, response always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = st_ff.rdata;
  assign overflow_irq = st_ff.irq;
  assign overflow_irq_high = st_ff.irq_high;
  assign cpu_on_osc_clock = st_ff.status;
  assign sec_idle_mode = st_ff.idle;
  assign osc_enable_out = st_ff.ctrl[CTL_OSC_EN];
  assign osc_low_power = st_ff.lp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_count_wraps: assert property (@(posedge hclk) disable iff (!hresetn)
    wrap && !sev && !wr_lo && !wr_hi |=> st_ff.count == 16'h0000)
    else $error("count did not wrap to zero");
  a_ovf_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    wrap && !sev |=> st_ff.flags[0] && overflow_irq == st_ff.enables[0])
    else $error("overflow flag or request wrong after wrap");
  a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    !st_ff.enables[0] && !(st_ff.dvalid && st_ff.dwrite) |=> !overflow_irq)
    else $error("masked overflow request issued");
  a_sev_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    sev && !wr_lo && !wr_hi |=> st_ff.count == 16'h0000)
    else $error("special event did not clear count");
  a_write_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_lo && sev |=> st_ff.count[7:0] == $past(hwdata[7:0]))
    else $error("special event beat software write");
  a_b_no_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    sev_b && !async_mode && !st_ff.flags[0] && !(st_ff.dvalid &&
    st_ff.dwrite) |=> !st_ff.flags[0])
    else $error("second compare reset set overflow flag");
  a_rearm_needed: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_lo || wr_hi) && async_mode |=> !st_ff.armed && !tick)
    else $error("count edge taken without falling edge");
  a_off_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    !st_ff.ctrl[0] [*3] ##0 !wr_lo && !wr_hi && !sev
    |=> $stable(st_ff.count))
    else $error("count moved while timer off");
  a_wide_snapshot: assert property (@(posedge hclk) disable iff (!hresetn)
    nxt_st.dvalid && !hwrite && aidx == IDX_CNT_LO && st_ff.ctrl[7] &&
    !wr_hi |=> st_ff.hbuf == $past(st_ff.count[15:8]))
    else $error("high byte buffer not loaded on low read");
  a_status_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    clock_monitor_fail |=> !cpu_on_osc_clock)
    else $error("status still shows failed oscillator");
  a_sec_run: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.pm == PM_PRIMARY && st_ff.oscctl[1:0] == 2'h1 && st_ff.ctrl[3]
    && !clock_monitor_fail |=> cpu_on_osc_clock)
    else $error("secondary run not entered");
  a_sec_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.pm == PM_SEC_RUN && sleep_exec && !st_ff.oscctl[7] &&
    !clock_monitor_fail && st_ff.oscctl[1:0] == 2'h1
    |=> sec_idle_mode)
    else $error("secondary idle not entered");
endmodule

// file: sim/sbt_clk_src.sv
// Model of the external count clock source seen by the timer
`timescale 1ns/100ps
module sbt_clk_src #(
  parameter int HALF = 6 // hclk cycles per half period
) (
  input wire logic hclk,
  input wire logic run, // burst gate from the bench
  output logic pin
);
  // ****
  // Burst generator
  // ****
  int cnt; // Cycles spent in the current half period
  initial begin
    pin = 1'b0;
    cnt = 0;
  end
  // A started period always ends low, so the pin stands still
  // between bursts instead of freezing high
  always @(posedge hclk) begin
    if (run || pin) begin
      if (cnt == HALF - 1) begin
        pin <= ~pin;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule

// file: sim/sixteen_bit_timer_with_rtc_support_tb_top.sv
// Self-checking testbench of the sixteen-bit timer block
`timescale 1ns/100ps
module sixteen_bit_timer_with_rtc_support_tb_top;
  import sbt_pkg::*;
  // ****
  // Signals and addresses
  // ****
  localparam logic [31:0] A_CTL = 32'(IDX_CTRL) << 2;
  localparam logic [31:0] A_LO = 32'(IDX_CNT_LO) << 2;
  localparam logic [31:0] A_HI = 32'(IDX_CNT_HI) << 2;
  localparam logic [31:0] A_FLG = 32'(IDX_FLAGS) << 2;
  localparam logic [31:0] A_EN = 32'(IDX_ENABLES) << 2;
  localparam logic [31:0] A_PRI = 32'(IDX_PRIO) << 2;
  localparam logic [31:0] A_OSC = 32'(IDX_OSCCTL) << 2;
  logic hclk = 1'b0; // 40 MHz bus clock
  logic hresetn = 1'b0; // Held low for ten cycles
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, pin, run = 1'b0;
  logic [1:0] uses = 2'h0; // Which compare unit uses the timer
  logic [3:0] mode = 4'h0; // Shared compare mode of both units
  logic [3:0] ev = 4'h0; // Pulses: wake, sleep, trig b, trig a
  logic cm_fail = 1'b0;
  logic lp_cfg = 1'b1; // Strap asks for low power
  logic irq, irq_hi, on_osc, sidle, osc_en, lp;
  int errors = 0;
  int n_checks = 0;
  always #12.5 hclk = ~hclk;
  sbt_clk_src #(.HALF(6)) src (.hclk(hclk), .run(run), .pin(pin));
  sbt_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .count_clk_pin(pin),
    .cmp_a_uses_timer(uses[0]), .compare_unit_a_mode(mode),
    .cmp_a_trig(ev[0]), .cmp_b_uses_timer(uses[1]),
    .compare_unit_b_mode(mode), .cmp_b_trig(ev[1]),
    .sleep_exec(ev[2]), .wake_event(ev[3]),
    .clock_monitor_fail(cm_fail), .osc_low_power_config(lp_cfg),
    .overflow_irq(irq), .overflow_irq_high(irq_hi),
    .cpu_on_osc_clock(on_osc), .sec_idle_mode(sidle),
    .osc_enable_out(osc_en), .osc_low_power(lp));
  // ****
  // Bus and check tasks
  // ****
  // Waits for the rising edge at which hready is sampled high; the
  // registered outputs still show their pre-edge values there
  task automatic wait_rdy;
    int t;
    t = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && t < 100) begin
      @(posedge hclk);
      t++;
    end
    if (t == 100) begin
      errors++;
      print_verdict();
    end
  endtask
  // One single word transfer; read data is taken at the closing edge
  task automatic bus(input logic w, input logic [31:0] a, d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  // Five pin periods, then the pin stands low
  task automatic burst;
    run <= 1'b1;
    repeat (60) @(posedge hclk);
    run <= 1'b0;
    repeat (20) @(posedge hclk);
  endtask
  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d);
  endtask
  // Range check; tolerance only where start-up phase is unknown
  task automatic chk(input logic [31:0] got, lo, hi);
    n_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h..%h",
        $time, got, lo, hi);
    end
  endtask
  task automatic rdc(input logic [31:0] a, lo, hi);
    bus(1'b0, a, 32'h0);
    chk(q, lo, hi);
  endtask
  // One-cycle event pulse, then time for it to land
  task automatic pulse(input int b);
    ev <= 4'(1 << b);
    @(posedge hclk);
    ev <= 4'h0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the roughly 1730 cycles of the run
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    print_verdict();
  end
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(A_CTL, 0, 0);
    wr(32'h40, 32'hff);
    rdc(32'h40, 0, 0);
    chk(32'(hresp), 0, 0);
    chk(32'(lp), 1, 1);
    // Each prescale code over 64 instruction cycles
    for (int ps = 0; ps < 4; ps++) begin
      wr(A_LO, 0);
      wr(A_HI, 0);
      wr(A_CTL, 32'(1 + ps * 16));
      repeat (256) @(posedge hclk);
      wr(A_CTL, 0);
      rdc(A_LO, (64 >> ps) - 1, (64 >> ps) + 1);
    end
    repeat (40) @(posedge hclk);
    rdc(A_LO, 7, 9);
    // Wrap from the top sets the sticky flag
    wr(A_LO, 32'hfe);
    wr(A_HI, 32'hff);
    wr(A_EN, 1);
    wr(A_PRI, 1);
    wr(A_CTL, 1);
    repeat (40) @(posedge hclk);
    wr(A_CTL, 0);
    rdc(A_HI, 0, 0);
    rdc(A_FLG, 1, 1);
    chk(32'(irq), 1, 1);
    chk(32'(irq_hi), 1, 1);
    wr(A_EN, 0);
    repeat (3) @(posedge hclk);
    chk(32'(irq), 0, 0);
    rdc(A_FLG, 1, 1);
    wr(A_FLG, 0);
    rdc(A_FLG, 0, 0);
    // Special event of either unit; compare mode 8 leaves the count
    for (int u = 0; u < 2; u++) begin
      uses <= 2'(1 << u);
      wr(A_HI, 32'h55);
      wr(A_LO, 0);
      wr(A_CTL, 32'h31);
      mode <= 4'h8;
      pulse(u);
      rdc(A_HI, 32'h55, 32'h55);
      mode <= MODE_SPECIAL_EVENT;
      pulse(u);
      rdc(A_HI, 0, 0);
      // Clear from the top; left alone the pair would wrap in 32 cycles
      wr(A_HI, 32'hff);
      wr(A_LO, 32'hff);
      pulse(u);
      repeat (40) @(posedge hclk);
      rdc(A_FLG, 0, 0);
    end
    // Unsynchronized mode ignores the event
    wr(A_HI, 32'h55);
    wr(A_CTL, 32'h07);
    pulse(1);
    rdc(A_HI, 32'h55, 32'h55);
    // First rise after an update with the pin low is lost
    wr(A_LO, 0);
    burst();
    rdc(A_LO, 4, 4);
    // Synchronized counter sees every rise
    wr(A_CTL, 32'h03);
    wr(A_LO, 0);
    burst();
    rdc(A_LO, 5, 5);
    // Timekeeping: async count, request enabled, oscillator kept on
    wr(A_CTL, 32'h0f);
    wr(A_EN, 1);
    wr(A_HI, 32'hff);
    wr(A_LO, 32'hfd);
    burst();
    rdc(A_LO, 1, 1);
    chk(32'(irq & osc_en), 1, 1);
    // Handler sets only the high byte msb; the low byte runs on
    wr(A_HI, 32'h80);
    wr(A_FLG, 0);
    burst();
    rdc(A_LO, 5, 5);
    rdc(A_HI, 32'h80, 32'h80);
    // Wide mode pairs the bytes through the buffer
    wr(A_CTL, 32'h80);
    wr(A_HI, 32'h12);
    wr(A_LO, 32'h34);
    wr(A_HI, 32'h77);
    rdc(A_LO, 32'h34, 32'h34);
    rdc(A_HI, 32'h12, 32'h12);
    wr(A_CTL, 0);
    rdc(A_HI, 32'h12, 32'h12);
    // Clocking from the timer oscillator
    wr(A_CTL, 32'h08);
    wr(A_OSC, 32'h01);
    repeat (3) @(posedge hclk);
    rdc(A_CTL, 32'h48, 32'h48);
    chk(32'(on_osc & osc_en), 1, 1);
    pulse(2);
    chk(32'(sidle), 1, 1);
    pulse(3);
    wr(A_OSC, 32'h81);
    pulse(2);
    chk(32'(sidle), 0, 0);
    cm_fail <= 1'b1;
    repeat (3) @(posedge hclk);
    rdc(A_CTL, 32'h08, 32'h08);
    chk(32'(on_osc), 0, 0);
    print_verdict();
  end
endmodule
